// ### design/cal_coef.sv
/*
 * Calibration coefficient storage and conversion correction.
 * Holds offset and gain coefficients in six byte registers, corrects raw
 * conversion words and flags calibration results at the coefficient limits.
 * Assumes a synchronous byte register port and a calibration engine outside
 * that presents results as one-cycle strobes.
 */
// Functional notes
// RQ1: keep 24-bit offset and gain coefficients
// RQ2: software reads and writes both coefficients
// RQ3: offset is signed, three bytes high/mid/low
// RQ4: bit weights fixed by converter variant
// RQ5: offset at full scale raises error
// RQ6: gain unsigned fixed point, three bytes
// RQ7: gain at either endpoint raises error
// RQ8: offset shifts conversion zero point
// RQ9: gain sets conversion slope
// RQ10: subtract offset, then multiply by gain
// RQ11: finished calibration loads matching coefficient
// RQ12: byte writes affect later conversions only
module cal_coef
   import cal_pkg::*;
#(
   parameter int W = 24
) (
   // clock, reset, enable
   input  wire logic                        i_clk,
   input  wire logic                        i_rst,
   input  wire logic                        i_ce,
   // byte register port
   input  wire logic [cal_pkg::ADDR_W-1:0]  i_reg_addr,
   input  wire logic                        i_reg_wr,
   input  wire logic [cal_pkg::BYTE_W-1:0]  i_reg_wdata,
   output logic [cal_pkg::BYTE_W-1:0]       o_reg_rdata,
   // calibration results
   input  wire logic                        i_ofs_cal_done,
   input  wire logic                        i_gan_cal_done,
   input  wire logic [W-1:0]                i_cal_result,
   input  wire logic                        i_err_clr,
   output logic                             o_cal_err,
   // raw conversion word in
   input  wire logic                        i_conv_valid,
   input  wire logic [W-1:0]                i_conv_data,
   output logic                             o_conv_busy,
   // corrected conversion word out
   output logic                             o_out_valid,
   output logic [W-1:0]                     o_out_data
);
   import cal_pkg::*;

   // coefficient storage [RQ1]
   logic [W-1:0] ofs_ff;
   logic [W-1:0] gan_ff;
   logic [W-1:0] nxt_ofs;
   logic [W-1:0] nxt_gan;
   logic         err_ff;
   logic         nxt_err;
   cal_state_t   st_ff;
   cal_state_t   nxt_st;
   logic [W-1:0] raw_ff;
   logic [W:0]   diff_ff;
   logic [W-1:0] ofs_snap_ff;
   logic [W-1:0] gan_snap_ff;

   // replace one byte lane of a coefficient
   function automatic logic [W-1:0] put_byte(input logic [W-1:0] c,
                                             input logic [BYTE_W-1:0] b,
                                             input int pos);
      logic [W-1:0] m;
      m = {{(W-BYTE_W){1'b0}}, {BYTE_W{1'b1}}} << pos;
      put_byte = (c & ~m) | ({{(W-BYTE_W){1'b0}}, b} << pos);
   endfunction

   // pick one byte lane of a coefficient
   function automatic logic [BYTE_W-1:0] get_byte(input logic [W-1:0] c,
                                                  input int pos);
      logic [W-1:0] s;
      s = c >> pos;
      get_byte = s[BYTE_W-1:0];
   endfunction

   // register decode
   wire logic wr_ofs_hi = i_reg_wr && (i_reg_addr == REG_OFS_HI);
   wire logic wr_ofs_md = i_reg_wr && (i_reg_addr == REG_OFS_MD);
   wire logic wr_ofs_lo = i_reg_wr && (i_reg_addr == REG_OFS_LO);
   wire logic wr_gan_hi = i_reg_wr && (i_reg_addr == REG_GAN_HI);
   wire logic wr_gan_md = i_reg_wr && (i_reg_addr == REG_GAN_MD);
   wire logic wr_gan_lo = i_reg_wr && (i_reg_addr == REG_GAN_LO);

   // limit detection on incoming calibration results
   wire logic ofs_lim = (i_cal_result == OFS_POS_FS)
                        || (i_cal_result == OFS_NEG_FS);        // [RQ5]
   wire logic gan_lim = (i_cal_result == GAN_MIN)
                        || (i_cal_result == GAN_MAX);           // [RQ7]
   wire logic err_set = (i_ofs_cal_done && ofs_lim) || (i_gan_cal_done && gan_lim);

   // offset next value: calibration result wins over a same-cycle byte write
   always_comb begin
      nxt_ofs = ofs_ff;
      if (wr_ofs_hi) nxt_ofs = put_byte(nxt_ofs, i_reg_wdata, POS_HI);  // [RQ3] [RQ2]
      if (wr_ofs_md) nxt_ofs = put_byte(nxt_ofs, i_reg_wdata, POS_MD);  // [RQ3]
      if (wr_ofs_lo) nxt_ofs = put_byte(nxt_ofs, i_reg_wdata, POS_LO);  // [RQ3]
      if (i_ofs_cal_done) nxt_ofs = i_cal_result;                       // [RQ11]
   end

   // gain next value, same priority
   always_comb begin
      nxt_gan = gan_ff;
      if (wr_gan_hi) nxt_gan = put_byte(nxt_gan, i_reg_wdata, POS_HI);  // [RQ6] [RQ2]
      if (wr_gan_md) nxt_gan = put_byte(nxt_gan, i_reg_wdata, POS_MD);  // [RQ6]
      if (wr_gan_lo) nxt_gan = put_byte(nxt_gan, i_reg_wdata, POS_LO);  // [RQ6]
      if (i_gan_cal_done) nxt_gan = i_cal_result;                       // [RQ11]
   end

   // sticky error flag, a new event beats the clear
   always_comb begin
      nxt_err = err_ff;
      if (i_err_clr) nxt_err = 1'b0;
      if (err_set) nxt_err = 1'b1;                              // [RQ5] [RQ7]
   end

   // read data mux
   always_comb begin
      case (i_reg_addr)
         REG_OFS_HI: o_reg_rdata = get_byte(ofs_ff, POS_HI);    // [RQ2]
         REG_OFS_MD: o_reg_rdata = get_byte(ofs_ff, POS_MD);
         REG_OFS_LO: o_reg_rdata = get_byte(ofs_ff, POS_LO);
         REG_GAN_HI: o_reg_rdata = get_byte(gan_ff, POS_HI);
         REG_GAN_MD: o_reg_rdata = get_byte(gan_ff, POS_MD);
         REG_GAN_LO: o_reg_rdata = get_byte(gan_ff, POS_LO);
         default:    o_reg_rdata = '0;
      endcase
   end

   // coefficient and flag registers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ofs_ff <= OFS_RST;
         gan_ff <= GAN_RST;
         err_ff <= 1'b0;
      end else if (i_ce) begin
         ofs_ff <= nxt_ofs;
         gan_ff <= nxt_gan;
         err_ff <= nxt_err;
      end
   end

   // correction sequencer: idle -> subtract -> multiply
   wire logic mul_done;
   always_comb begin
      case (st_ff)
         CAL_IDLE: nxt_st = i_conv_valid ? CAL_SUB : CAL_IDLE;
         CAL_SUB:  nxt_st = CAL_MUL;
         CAL_MUL:  nxt_st = mul_done ? CAL_IDLE : CAL_MUL;
         default:  nxt_st = CAL_IDLE;
      endcase
   end

   // sign-extended raw minus offset; coefficients snapped at acceptance
   // offset lsb weighs one raw-word lsb, sign bit carries the negative top weight [RQ4]
   wire logic [W:0] diff_w = {raw_ff[W-1], raw_ff} - {ofs_snap_ff[W-1], ofs_snap_ff};

   // datapath registers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_ff       <= CAL_IDLE;
         raw_ff      <= '0;
         diff_ff     <= '0;
         ofs_snap_ff <= OFS_RST;
         gan_snap_ff <= GAN_RST;
      end else if (i_ce) begin
         st_ff <= nxt_st;
         if (st_ff == CAL_IDLE && i_conv_valid) begin
            raw_ff      <= i_conv_data;
            ofs_snap_ff <= ofs_ff;                              // [RQ12]
            gan_snap_ff <= gan_ff;                              // [RQ12]
         end
         if (st_ff == CAL_SUB) begin
            diff_ff <= diff_w;                                  // [RQ8] [RQ10]
         end
      end
   end

   // gain multiply stage [RQ9] [RQ10]
   cal_mul #(
      .W (W)
   ) u_mul (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_ce    (i_ce),
      .i_start (st_ff == CAL_MUL && !mul_done),
      .i_diff  (diff_ff),
      .i_gain  (gan_snap_ff),
      .o_prod  (o_out_data),
      .o_done  (mul_done)
   );

   assign o_cal_err   = err_ff;
   assign o_conv_busy = (st_ff != CAL_IDLE);
   assign o_out_valid = mul_done && i_ce;
endmodule

// ### design/cal_mul.sv
/*
 * Signed-by-unsigned fixed-point multiply with saturation, one register stage.
 * Assumes the gain has one integer bit and the rest fractional.
 */
module cal_mul
   import cal_pkg::*;
#(
   parameter int W = 24
) (
   // clock and control
   input  wire logic          i_clk,
   input  wire logic          i_rst,
   input  wire logic          i_ce,
   input  wire logic          i_start,
   // operands
   input  wire logic [W:0]    i_diff,
   input  wire logic [W-1:0]  i_gain,
   // result
   output logic [W-1:0]       o_prod,
   output logic               o_done
);
   localparam int PW = 2 * W + 2;
   localparam logic signed [W-1:0] SMAX = {1'b0, {(W-1){1'b1}}};
   localparam logic signed [W-1:0] SMIN = {1'b1, {(W-1){1'b0}}};

   // full product then shift out the fractional gain bits
   wire logic signed [PW-1:0] full  = $signed(i_diff) * $signed({1'b0, i_gain});
   wire logic signed [PW-1:0] shft  = full >>> GAN_FRAC;
   wire logic                 hi_ov = shft > $signed({{(PW-W){1'b0}}, SMAX});
   wire logic                 lo_ov = shft < $signed({{(PW-W){1'b1}}, SMIN});
   wire logic [W-1:0]         sat   = hi_ov ? SMAX : (lo_ov ? SMIN : shft[W-1:0]);

   // register the saturated product
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_prod <= '0;
         o_done <= 1'b0;
      end else if (i_ce) begin
         o_done <= i_start;
         if (i_start) begin
            o_prod <= sat;
         end
      end
   end
endmodule

// ### design/cal_pkg.sv
/*
 * Shared constants for the converter calibration coefficient block.
 * Assumes a single system clock domain and byte-wide register access.
 */
package cal_pkg;
   localparam int          COEF_W     = 24;
   localparam int          BYTE_W     = 8;
   localparam int          ADDR_W     = 3;
   // register indices on the byte register port
   localparam logic [2:0]  REG_OFS_HI = 3'h0;
   localparam logic [2:0]  REG_OFS_MD = 3'h1;
   localparam logic [2:0]  REG_OFS_LO = 3'h2;
   localparam logic [2:0]  REG_GAN_HI = 3'h3;
   localparam logic [2:0]  REG_GAN_MD = 3'h4;
   localparam logic [2:0]  REG_GAN_LO = 3'h5;
   // byte field positions within a coefficient
   localparam int          POS_HI     = 16;
   localparam int          POS_MD     = 8;
   localparam int          POS_LO     = 0;
   // reset values (no documented value; offset zero, gain unity)
   localparam logic [23:0] OFS_RST    = 24'h000000;
   localparam logic [23:0] GAN_RST    = 24'h800000;
   // calibration limit codes
   localparam logic [23:0] OFS_POS_FS = 24'h7FFFFF;
   localparam logic [23:0] OFS_NEG_FS = 24'h800000;
   localparam logic [23:0] GAN_MIN    = 24'h000000;
   localparam logic [23:0] GAN_MAX    = 24'hFFFFFF;
   // gain has one integer bit, so products shift right by this
   localparam int          GAN_FRAC   = 23;
   // correction pipeline states
   typedef enum logic [1:0] {CAL_IDLE, CAL_SUB, CAL_MUL} cal_state_t;
endpackage

// ### testbench/cal_coef_checker.sv
/* Assertion checker for cal_coef, bound to the top module's ports.
   Assumes one clock and an asynchronous active-high reset. */
module cal_coef_checker
   import cal_pkg::*;
#(
   parameter int W = 24
) (
   // clock, reset and byte register port
   input  wire logic                       i_clk,
   input  wire logic                       i_rst,
   input  wire logic                       i_ce,
   input  wire logic                       i_reg_wr,
   input  wire logic [cal_pkg::ADDR_W-1:0] i_reg_addr,
   input  wire logic [cal_pkg::BYTE_W-1:0] i_reg_wdata,
   input  wire logic [cal_pkg::BYTE_W-1:0] o_reg_rdata,
   // calibration
   input  wire logic                       i_ofs_cal_done,
   input  wire logic                       i_gan_cal_done,
   input  wire logic                       i_err_clr,
   input  wire logic                       o_cal_err,
   input  wire logic [W-1:0]               i_cal_result,
   // conversion
   input  wire logic                       i_conv_valid,
   input  wire logic                       o_conv_busy,
   input  wire logic                       o_out_valid,
   input  wire logic [W-1:0]               i_conv_data,
   input  wire logic [W-1:0]               o_out_data
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   // accepted calibration strobes
   wire ofs_tk = i_ofs_cal_done && i_ce;
   wire gan_tk = i_gan_cal_done && i_ce;
   // a conversion is taken, then answered after two busy cycles
   sequence s_take;
      i_conv_valid && !o_conv_busy && i_ce;
   endsequence
   sequence s_answer;
      o_conv_busy [*2] ##1 o_out_valid;
   endsequence
   property p_ofs_err;
      ofs_tk && (i_cal_result == OFS_POS_FS || i_cal_result == OFS_NEG_FS) |=> o_cal_err;
   endproperty
   property p_gan_err;
      gan_tk && (i_cal_result == GAN_MIN || i_cal_result == GAN_MAX) |=> o_cal_err;
   endproperty
   property p_err_hold;
      o_cal_err && !i_err_clr |=> o_cal_err;
   endproperty
   property p_err_cause;
      $rose(o_cal_err) |-> $past(ofs_tk || gan_tk);
   endproperty
   property p_ofs_load;
      ofs_tk && !i_reg_wr && i_reg_addr == REG_OFS_HI ##1 i_reg_addr == REG_OFS_HI
         |-> o_reg_rdata == $past(i_cal_result[23:16]);
   endproperty
   property p_wr_read;
      i_reg_wr && i_ce && i_reg_addr <= REG_GAN_LO && !ofs_tk && !gan_tk ##1 $stable(i_reg_addr)
         |-> o_reg_rdata == $past(i_reg_wdata);
   endproperty
   property p_conv;
      s_take |=> s_answer;
   endproperty
   property p_pulse;
      o_out_valid |=> !o_out_valid;
   endproperty
   property p_hold;
      !o_out_valid |-> $stable(o_out_data);
   endproperty
   a_ofs_err: assert property (p_ofs_err) else $error("offset limit not flagged");
   a_gan_err: assert property (p_gan_err) else $error("gain limit not flagged");
   a_err_hold: assert property (p_err_hold) else $error("error flag lost");
   a_err_cause: assert property (p_err_cause) else $error("error flag without cause");
   a_ofs_load: assert property (p_ofs_load) else $error("offset not loaded");
   a_wr_read: assert property (p_wr_read) else $error("byte write not read back");
   a_conv: assert property (p_conv) else $error("conversion latency wrong");
   a_pulse: assert property (p_pulse) else $error("valid longer than a cycle");
   a_hold: assert property (p_hold) else $error("result changed without valid");
endmodule

bind cal_coef cal_coef_checker #(.W(W)) u_chk (
   .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_ofs_cal_done(i_ofs_cal_done),
   .i_gan_cal_done(i_gan_cal_done), .i_err_clr(i_err_clr), .o_cal_err(o_cal_err),
   .i_conv_valid(i_conv_valid), .o_conv_busy(o_conv_busy), .o_out_valid(o_out_valid),
   .i_cal_result(i_cal_result), .i_conv_data(i_conv_data), .o_out_data(o_out_data)
);

// ### testbench/cal_coef_tb.sv
/* Self-checking bench for cal_coef with a byte-level coefficient model.
   Assumes the checker is bound from its own file; inputs move on falling edges. */
module cal_coef_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cal_pkg::*;
   logic        i_clk, i_rst, i_ce, i_reg_wr, i_ofs_cal_done, i_gan_cal_done, i_err_clr;
   logic        i_conv_valid, o_cal_err, o_conv_busy, o_out_valid;
   logic [2:0]  i_reg_addr;
   logic [7:0]  i_reg_wdata, o_reg_rdata;
   logic [23:0] i_cal_result, i_conv_data, o_out_data;
   logic [47:0] m_cat;
   int          n_fail, checks, seed;
   // device under test
   cal_coef #(.W(24)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_reg_addr(i_reg_addr),
      .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .i_ofs_cal_done(i_ofs_cal_done), .i_gan_cal_done(i_gan_cal_done),
      .i_cal_result(i_cal_result), .i_err_clr(i_err_clr), .o_cal_err(o_cal_err),
      .i_conv_valid(i_conv_valid), .i_conv_data(i_conv_data), .o_conv_busy(o_conv_busy),
      .o_out_valid(o_out_valid), .o_out_data(o_out_data));
   // 200 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run;
      if (n_fail == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // read all eight indices against the model, unmapped ones read zero
   task automatic chk_regs;
      for (int a = 0; a < 8; a++) begin
         i_reg_addr = a[2:0];
         #1;
         chk("rdata", o_reg_rdata, (a < 6) ? m_cat[47 - 8 * a -: 8] : 8'h00);
         @(negedge i_clk);
      end
   endtask
   task automatic wr(input int a, input logic [7:0] d);
      i_reg_addr = a[2:0];
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      if (a < 6 && i_ce) m_cat[47 - 8 * a -: 8] = d;
      @(negedge i_clk);
      i_reg_wr = 1'b0;
      @(negedge i_clk);
   endtask
   // clear the flag, then offer a result while the clear still stands: a new error wins
   task automatic cal(input bit g, input logic [23:0] r);
      i_err_clr = 1'b1;
      @(negedge i_clk);
      i_reg_addr = g ? REG_GAN_HI : REG_OFS_HI;
      i_cal_result = r;
      i_ofs_cal_done = !g;
      i_gan_cal_done = g;
      @(negedge i_clk);
      i_err_clr = 1'b0;
      i_ofs_cal_done = 1'b0;
      i_gan_cal_done = 1'b0;
      if (g) m_cat[23:0] = r;
      else m_cat[47:24] = r;
      chk("cal_err", o_cal_err, g ? (r == 0 || r == 24'hFFFFFF) : (r == 24'h7FFFFF || r == 24'h800000));
      @(negedge i_clk);
   endtask
   // one conversion; a second offer during busy must be ignored
   task automatic conv(input logic [23:0] raw);
      longint d;
      int k;
      d = (longint'($signed(raw)) - longint'($signed(m_cat[47:24]))) * longint'(m_cat[23:0]);
      d = d >>> 23;
      if (d > 64'sh7FFFFF) d = 64'sh7FFFFF;
      if (d < -64'sh800000) d = -64'sh800000;
      i_conv_valid = 1'b1;
      i_conv_data = raw;
      @(negedge i_clk);
      chk("conv_busy", o_conv_busy, 1'b1);
      i_conv_data = ~raw;
      @(negedge i_clk);
      i_conv_valid = 1'b0;
      k = 0;
      while (o_out_valid !== 1'b1 && k < 8) begin
         @(negedge i_clk);
         k++;
      end
      chk("out_valid", o_out_valid, 1'b1);
      chk("out_data", o_out_data, d[23:0]);
      @(negedge i_clk);
      chk("conv_idle", o_conv_busy, 1'b0);
   endtask
   // main sequence
   initial begin
      {i_ce, i_reg_wr, i_ofs_cal_done, i_gan_cal_done, i_err_clr, i_conv_valid} = 6'h20;
      {i_reg_addr, i_reg_wdata, i_cal_result, i_conv_data} = '0;
      i_rst = 1'b1;
      seed = 41;
      m_cat = {OFS_RST, GAN_RST};
      repeat (16) @(negedge i_clk);
      i_rst = 1'b0;
      chk_regs();
      for (int a = 0; a < 7; a++) wr(a, $random(seed));
      i_ce = 1'b0;
      wr(1, 8'hA5);
      i_ce = 1'b1;
      chk_regs();
      cal(0, 24'h7FFFFF);
      cal(0, 24'h800000);
      cal(1, 24'h000000);
      cal(1, 24'hFFFFFF);
      cal(1, 24'h940000);
      cal(0, $random(seed));
      chk_regs();
      for (int n = 0; n < 24; n++) begin
         if (n % 4 == 1) wr(n % 6, $random(seed));
         if (n % 8 == 3) cal(n % 16 == 3, $random(seed));
         conv(n < 2 ? {n[0], {23{!n[0]}}} : $random(seed));
      end
      // mid-run reset returns every register to its reset value
      i_rst = 1'b1;
      m_cat = {OFS_RST, GAN_RST};
      repeat (2) @(negedge i_clk);
      chk("rst_err", o_cal_err, 1'b0);
      chk("rst_out", o_out_data, 24'h000000);
      i_rst = 1'b0;
      chk_regs();
      conv($random(seed));
      complete_run();
   end
   // watchdog against a hang
   initial begin
      #20000;
      n_fail++;
      complete_run();
   end
endmodule
